//--- dtc_regs.svh
// Register indices, field positions, reset values and prescale counts
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH
`define DTC_IDX_CONTROL_FLAGS 8'h88
`define DTC_IDX_MODE_SELECT 8'h89
`define DTC_IDX_T0_LOW 8'h8A
`define DTC_IDX_T1_LOW 8'h8B
`define DTC_IDX_T0_HIGH 8'h8C
`define DTC_IDX_T1_HIGH 8'h8D
`define DTC_IDX_PRESCALE 8'h8F
`define DTC_IDX_IRQ_STATUS 8'h90
`define DTC_IDX_IRQ_MASK 8'h91
`define DTC_BIT_T1_FLAG 7
`define DTC_BIT_T1_RUN 6
`define DTC_BIT_T0_FLAG 5
`define DTC_BIT_T0_RUN 4
`define DTC_BIT_GATE 3
`define DTC_BIT_CT_SEL 2
`define DTC_MODE_W 2
`define DTC_TIMER_MODE_SELECT_STRIDE 4
`define DTC_PRESCALE_MASK 8'h3F
`define DTC_RESET_BYTE 8'h00
`define DTC_DIV_SEL00 4'hC
`define DTC_DIV_SEL01 4'h6
`define DTC_DIV_SEL10 4'h4
`define DTC_DIV_SEL11 4'h1
`endif

//--- dtc_pkg.sv
// Types shared by the dual timer block
`default_nettype none
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE_13BIT = 2'b00,
        DTC_MODE_16BIT = 2'b01,
        DTC_MODE_8RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_t;

    typedef struct packed {
        logic [7:0] timer_control_flags;
        logic [7:0] timer_mode_select;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic [7:0] timer_prescale_select;
        logic [1:0] stat;
        logic [1:0] mask;
        logic irq;
        logic waitreq;
        logic [7:0] rdata;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_s3;
        logic [1:0] gate_s1;
        logic [1:0] gate_s2;
    } dtc_state_t;

    typedef struct packed {
        logic [1:0][3:0] cnt;
        logic [1:0] tick;
    } dtc_presc_state_t;
endpackage : dtc_pkg
`default_nettype wire

//--- dtc_tick_if.sv
// Prescale selects out to the divider and count ticks back
`default_nettype none
interface dtc_tick_if;
    logic [1:0][1:0] sel;
    logic [1:0] tick;
    modport src (input sel, output tick);
    modport dst (output sel, input tick);
endinterface : dtc_tick_if
`default_nettype wire

//--- dtc_prescaler.sv
// Per-timer system clock divider producing one-cycle count ticks
`include "dtc_regs.svh"
`default_nettype none
module dtc_prescaler #(
    parameter int CNT_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_n,
    dtc_tick_if.src tk
);
    dtc_pkg::dtc_presc_state_t st_ff;
    dtc_pkg::dtc_presc_state_t nxt_st;

    if (CNT_W != 4)
    begin : g_bad_width
        $error("dtc_prescaler: CNT_W must be 4");
    end

    function automatic logic [3:0] dtc_div(input logic [1:0] sel);
        unique case (sel)
            2'b00: dtc_div = `DTC_DIV_SEL00;
            2'b01: dtc_div = `DTC_DIV_SEL01;
            2'b10: dtc_div = `DTC_DIV_SEL10;
            2'b11: dtc_div = `DTC_DIV_SEL11;
        endcase
    endfunction : dtc_div

    // Counter is not restarted on a select change; the first tick after it may come early
    always_comb
    begin
        nxt_st = st_ff;
        for (int i = 0; i < 2; i++)
        begin
            if (st_ff.cnt[i] >= dtc_div(tk.sel[i]) - 4'h1)
            begin
                nxt_st.cnt[i] = 4'h0;
                nxt_st.tick[i] = 1'b1;
            end
            else
            begin
                nxt_st.cnt[i] = st_ff.cnt[i] + 4'h1;
                nxt_st.tick[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tk.tick = st_ff.tick;

    a_presc_div12: assert property (@(posedge clk_i) disable iff (!rst_n)
        (tk.sel[0] == 2'b00 && st_ff.cnt[0] == 4'hB) |=> (tk.tick[0] && st_ff.cnt[0] == 4'h0))
        else $error("divide-by-12 tick missing");
endmodule : dtc_prescaler
`default_nettype wire

//--- dtc_top.sv
// Dual timer/event counter with Avalon-MM register slave
// Summary of operation
// - Two-bit mode field per timer: 13-bit, 16-bit, 8-bit reload, split.
// - Running counter increments per prescaled tick or per falling edge on the external pin.
// - Non-reload modes wrap to zero after passing full count.
// - 13-bit mode uses low five bits of low byte plus high byte.
// - 13-bit mode: high byte holds bits 12..5; low byte top bits read zero.
// - 16-bit mode: low byte is low half, high byte is high half.
// - 8-bit reload mode: low byte reloads from high byte on overflow, flag set.
// - Timer 1 in mode 11 stops; split mode belongs to timer 0 only.
// - Split low counter times or counts; split high counter only times.
// - Split high counter runs under timer 1 run control.
// - Split high overflow sets timer 1 flag; low overflow sets timer 0 flag.
// - One select bit per timer picks internal ticks or external transitions.
// - Gating: count only while run bit set and gate pin high.
// - Clearing run bit only halts; counts keep their values.
// - Prescale field: divide by 12, 6, 4 or undivided system clock.
// - Overflow sets request flag; interrupt only when enabled.
// - All count, mode, control and prescale registers reset to zero.
//
// Our own choice: the Avalon-MM slave port.
`include "dtc_regs.svh"
`default_nettype none
module dtc_top #(
    parameter int ADDR_W = 10
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic [1:0] cnt_pin_i,
    input wire logic [1:0] ext_gate_pin_i,
    input wire logic [1:0] int_ack_i,
    output logic [1:0] overflow_flag_o,
    output logic irq_o
);
    logic [1:0] rst_sync_ff;
    logic rst_n;
    dtc_pkg::dtc_state_t st_ff;
    dtc_pkg::dtc_state_t nxt_st;
    dtc_tick_if tk ();

    if (ADDR_W < 10)
    begin : g_bad_addr
        $error("dtc_top: ADDR_W must be at least 10");
    end

    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_sync_ff <= 2'b00;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    dtc_prescaler #(.CNT_W(4)) u_presc (
        .clk_i(clk_i),
        .rst_n(rst_n),
        .tk(tk)
    );

    function automatic logic [16:0] dtc_step(input dtc_pkg::dtc_mode_t mode,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi,
                                             input logic inc);
        logic [12:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        c8 = {1'b0, lo} + 9'h001;
        dtc_step = {1'b0, hi, lo};
        if (inc)
        begin
            unique case (mode)
                dtc_pkg::DTC_MODE_13BIT:
                    dtc_step = {(&{hi, lo[4:0]}), c13[12:5], 3'h0, c13[4:0]};
                dtc_pkg::DTC_MODE_16BIT:
                    dtc_step = c16;
                dtc_pkg::DTC_MODE_8RELOAD:
                    dtc_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
                dtc_pkg::DTC_MODE_SPLIT:
                    dtc_step = {c8[8], hi, c8[7:0]};
            endcase
        end
    endfunction : dtc_step

    dtc_pkg::dtc_mode_t mode0;
    dtc_pkg::dtc_mode_t mode1;
    logic [1:0] fall;
    logic [1:0] run;
    logic [1:0] gate_en;
    logic [1:0] ct_sel;
    logic [1:0] inc;
    logic split0;
    logic hi_inc;
    logic [8:0] hi9;
    logic [16:0] s0;
    logic [16:0] s1;
    logic [1:0] ovf;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic wr_now;
    logic first_cyc;
    logic [7:0] rd_mux;

    always_comb
    begin
        mode0 = dtc_pkg::dtc_mode_t'(st_ff.timer_mode_select[1:0]);
        mode1 = dtc_pkg::dtc_mode_t'(st_ff.timer_mode_select[`DTC_TIMER_MODE_SELECT_STRIDE +: `DTC_MODE_W]);
        split0 = (mode0 == dtc_pkg::DTC_MODE_SPLIT);
        run = {st_ff.timer_control_flags[`DTC_BIT_T1_RUN], st_ff.timer_control_flags[`DTC_BIT_T0_RUN]};
        for (int i = 0; i < 2; i++)
        begin
            fall[i] = st_ff.pin_s3[i] & ~st_ff.pin_s2[i];
            gate_en[i] = st_ff.timer_mode_select[`DTC_BIT_GATE + `DTC_TIMER_MODE_SELECT_STRIDE * i];
            ct_sel[i] = st_ff.timer_mode_select[`DTC_BIT_CT_SEL + `DTC_TIMER_MODE_SELECT_STRIDE * i];
            // Gate pin low only pauses, so pulse width can be measured
            inc[i] = run[i] & (~gate_en[i] | st_ff.gate_s2[i])
                     & (ct_sel[i] ? fall[i] : tk.tick[i]);
        end
        s0 = dtc_step(mode0, st_ff.tl0, st_ff.th0, inc[0]);
        s1 = dtc_step(mode1, st_ff.tl1, st_ff.th1,
                      inc[1] & (mode1 != dtc_pkg::DTC_MODE_SPLIT));
        hi_inc = split0 & run[1] & tk.tick[0];
        hi9 = {1'b0, st_ff.th0} + 9'h001;
        // Timer 1 loses its flag to the split high counter, as in the classic part
        ovf[0] = s0[16];
        ovf[1] = split0 ? (hi_inc & hi9[8]) : s1[16];
    end

    always_comb
    begin
        idx = address_i[9:2];
        wdata = writedata_i[7:0];
        first_cyc = (read_i | write_i) & st_ff.waitreq;
        wr_now = write_i & ~st_ff.waitreq & byteenable_i[0];
        unique case (idx)
            `DTC_IDX_CONTROL_FLAGS: rd_mux = st_ff.timer_control_flags;
            `DTC_IDX_MODE_SELECT: rd_mux = st_ff.timer_mode_select;
            `DTC_IDX_T0_LOW: rd_mux = (mode0 == dtc_pkg::DTC_MODE_13BIT) ?
                                      {3'h0, st_ff.tl0[4:0]} : st_ff.tl0;
            `DTC_IDX_T1_LOW: rd_mux = (mode1 == dtc_pkg::DTC_MODE_13BIT) ?
                                      {3'h0, st_ff.tl1[4:0]} : st_ff.tl1;
            `DTC_IDX_T0_HIGH: rd_mux = st_ff.th0;
            `DTC_IDX_T1_HIGH: rd_mux = st_ff.th1;
            `DTC_IDX_PRESCALE: rd_mux = st_ff.timer_prescale_select;
            `DTC_IDX_IRQ_STATUS: rd_mux = {6'h00, st_ff.stat};
            `DTC_IDX_IRQ_MASK: rd_mux = {6'h00, st_ff.mask};
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pin_s1 = cnt_pin_i;
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.pin_s3 = st_ff.pin_s2;
        nxt_st.gate_s1 = ext_gate_pin_i;
        nxt_st.gate_s2 = st_ff.gate_s1;

        // Counting first; a software write in the same cycle overrides it
        nxt_st.tl0 = s0[7:0];
        nxt_st.th0 = split0 ? (hi_inc ? hi9[7:0] : st_ff.th0) : s0[15:8];
        nxt_st.tl1 = s1[7:0];
        nxt_st.th1 = s1[15:8];
        nxt_st.timer_control_flags[`DTC_BIT_T0_FLAG] = st_ff.timer_control_flags[`DTC_BIT_T0_FLAG] & ~int_ack_i[0];
        nxt_st.timer_control_flags[`DTC_BIT_T1_FLAG] = st_ff.timer_control_flags[`DTC_BIT_T1_FLAG] & ~int_ack_i[1];
        nxt_st.stat = st_ff.stat;

        // Two-cycle handshake: waitrequest drops for one cycle with data ready
        if (first_cyc)
        begin
            nxt_st.waitreq = 1'b0;
            nxt_st.rdata = rd_mux;
        end
        else
        begin
            nxt_st.waitreq = 1'b1;
        end

        if (wr_now)
        begin
            unique case (idx)
                `DTC_IDX_CONTROL_FLAGS: nxt_st.timer_control_flags = wdata;
                `DTC_IDX_MODE_SELECT: nxt_st.timer_mode_select = wdata;
                `DTC_IDX_T0_LOW: nxt_st.tl0 = wdata;
                `DTC_IDX_T1_LOW: nxt_st.tl1 = wdata;
                `DTC_IDX_T0_HIGH: nxt_st.th0 = wdata;
                `DTC_IDX_T1_HIGH: nxt_st.th1 = wdata;
                `DTC_IDX_PRESCALE: nxt_st.timer_prescale_select = wdata & `DTC_PRESCALE_MASK;
                `DTC_IDX_IRQ_STATUS: nxt_st.stat = st_ff.stat & ~wdata[1:0];
                `DTC_IDX_IRQ_MASK: nxt_st.mask = wdata[1:0];
                default: nxt_st.stat = st_ff.stat;
            endcase
        end

        // Hardware set wins over any clear in the same cycle
        nxt_st.timer_control_flags[`DTC_BIT_T0_FLAG] = nxt_st.timer_control_flags[`DTC_BIT_T0_FLAG] | ovf[0];
        nxt_st.timer_control_flags[`DTC_BIT_T1_FLAG] = nxt_st.timer_control_flags[`DTC_BIT_T1_FLAG] | ovf[1];
        nxt_st.stat = nxt_st.stat | ovf;
        nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
            st_ff.waitreq <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // One driver for the whole select word keeps the interface variable single-sourced
    assign tk.sel = {st_ff.timer_prescale_select[3:2], st_ff.timer_prescale_select[1:0]};
    assign readdata_o = {24'h000000, st_ff.rdata};
    assign waitrequest_o = st_ff.waitreq;
    assign irq_o = st_ff.irq;
    assign overflow_flag_o = {st_ff.timer_control_flags[`DTC_BIT_T1_FLAG], st_ff.timer_control_flags[`DTC_BIT_T0_FLAG]};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    a_run_hold_low: assert property (
        (!st_ff.timer_control_flags[`DTC_BIT_T0_RUN] && !wr_now) |=> $stable(st_ff.tl0))
        else $error("timer 0 low byte moved while stopped");

    a_gate_blocks: assert property (
        (st_ff.timer_mode_select[`DTC_BIT_GATE] && !st_ff.gate_s2[0] && !wr_now) |=> $stable(st_ff.tl0))
        else $error("timer 0 counted with gate pin low");

    a_reload_high: assert property (
        (mode0 == dtc_pkg::DTC_MODE_8RELOAD && st_ff.tl0 == 8'hFF && inc[0] && !wr_now)
        |=> (st_ff.tl0 == $past(st_ff.th0) && st_ff.timer_control_flags[`DTC_BIT_T0_FLAG]))
        else $error("reload from high byte missing");

    a_wrap_sixteen: assert property (
        (mode0 == dtc_pkg::DTC_MODE_16BIT && {st_ff.th0, st_ff.tl0} == 16'hFFFF
         && inc[0] && !wr_now)
        |=> ({st_ff.th0, st_ff.tl0} == 16'h0000 && st_ff.timer_control_flags[`DTC_BIT_T0_FLAG]))
        else $error("16-bit wrap to zero missing");

    a_thirteen_read: assert property (
        (read_i && st_ff.waitreq && idx == `DTC_IDX_T0_LOW
         && mode0 == dtc_pkg::DTC_MODE_13BIT)
        |=> (readdata_o[7:5] == 3'h0 && !waitrequest_o))
        else $error("13-bit low byte upper bits not zero");

    a_t1_split_stop: assert property (
        (mode1 == dtc_pkg::DTC_MODE_SPLIT && !wr_now) |=> $stable({st_ff.th1, st_ff.tl1}))
        else $error("timer 1 counted in mode 11");

    a_split_high_run: assert property (
        (split0 && !st_ff.timer_control_flags[`DTC_BIT_T1_RUN] && !wr_now) |=> $stable(st_ff.th0))
        else $error("split high counter ran without timer 1 run");

    a_split_flag_one: assert property (
        (split0 && hi_inc && st_ff.th0 == 8'hFF) |=> st_ff.timer_control_flags[`DTC_BIT_T1_FLAG] ##1 irq_o
        || !st_ff.mask[1] || st_ff.stat[1] == 1'b0)
        else $error("split high overflow did not flag timer 1");

    a_edge_once: assert property (
        (st_ff.timer_mode_select[`DTC_BIT_CT_SEL] && st_ff.tl0 != 8'hFF && !fall[0] && !wr_now)
        |=> $stable(st_ff.tl0))
        else $error("counter function moved without a falling edge");

    a_irq_level: assert property (
        irq_o == |(st_ff.stat & st_ff.mask))
        else $error("interrupt output disagrees with status and mask");
endmodule : dtc_top
`default_nettype wire

//--- dtc_pin_model.sv
// Partner model driving the external count and gate pins
`default_nettype none
module dtc_pin_model (
    input wire logic clk_i,
    output logic [1:0] cnt_pin_o,
    output logic [1:0] gate_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cnt_pin_o = 2'b11;
        gate_pin_o = 2'b00;
    end
    // Count pins idle high; each pulse stays low two cycles so the synchroniser cannot miss it
    task automatic pulse(input int ch, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            cnt_pin_o[ch] <= 1'b0;
            repeat (2) @(posedge clk_i);
            cnt_pin_o[ch] <= 1'b1;
            @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
    endtask : pulse
    task automatic set_gate(input int ch, input logic lvl);
        @(posedge clk_i);
        gate_pin_o[ch] <= lvl;
        repeat (3) @(posedge clk_i);
    endtask : set_gate
endmodule : dtc_pin_model
`default_nettype wire

//--- dual_timer_event_counter_tb.sv
// Self-checking bench for the dual timer/event counter
`include "dtc_regs.svh"
`default_nettype none
module dual_timer_event_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTL = `DTC_IDX_CONTROL_FLAGS;
    localparam logic [7:0] MOD = `DTC_IDX_MODE_SELECT;
    localparam logic [7:0] PRE = `DTC_IDX_PRESCALE;
    localparam logic [7:0] STA = `DTC_IDX_IRQ_STATUS;
    localparam logic [7:0] MSK = `DTC_IDX_IRQ_MASK;
    localparam logic [7:0] TL0 = `DTC_IDX_T0_LOW;
    localparam logic [7:0] TL1 = `DTC_IDX_T1_LOW;
    localparam logic [7:0] TH0 = `DTC_IDX_T0_HIGH;
    localparam logic [7:0] TH1 = `DTC_IDX_T1_HIGH;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [9:0] address_i = '0;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = '0;
    logic [1:0] int_ack_i = '0;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic [1:0] cnt_pin;
    logic [1:0] gate_pin;
    logic [1:0] overflow_flag_o;
    logic irq_o;
    logic [7:0] rd;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    dtc_top #(.ADDR_W(10)) i_dtc_top (.clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .cnt_pin_i(cnt_pin),
        .ext_gate_pin_i(gate_pin), .int_ack_i(int_ack_i), .overflow_flag_o(overflow_flag_o),
        .irq_o(irq_o));
    dtc_pin_model i_dtc_pin_model (.clk_i(clk_i), .cnt_pin_o(cnt_pin), .gate_pin_o(gate_pin));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_rng(input string what, input logic [7:0] lo, input logic [7:0] hi,
                           input logic [7:0] got);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            bad_count++;
            $display("ERROR %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask : chk_rng
    // Slave answer time is never assumed: poll waitrequest, bounded by a count
    task automatic bus(input logic [7:0] idx, input logic wr_en, input logic [7:0] wd,
                       output logic [7:0] rdv);
        int n;
        n = 0;
        @(posedge clk_i);
        address_i <= {idx, 2'b00};
        write_i <= wr_en;
        read_i <= !wr_en;
        writedata_i <= {24'h000000, wd};
        // Sampled at the rising edge; the write lands and read data stand at this edge
        do
        begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 50);
        rdv = readdata_o[7:0];
        chk("bus answer", 8'h00, {7'h00, waitrequest_o});
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        bus(idx, 1'b1, d, unused);
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00, rd);
        chk(what, exp, rd);
    endtask : rdc
    task automatic t_reset();
        logic [7:0] idx [9] = '{CTL, MOD, TL0, TL1, TH0, TH1, PRE, STA, MSK};
        foreach (idx[i])
        begin
            rdc("reset value", idx[i], 8'h00);
        end
        wr(8'h8E, 8'hA5);
        rdc("unmapped", 8'h8E, 8'h00);
        wr(PRE, 8'hFF);
        rdc("prescale", PRE, 8'h3F);
        wr(MOD, 8'hA5);
        rdc("mode", MOD, 8'hA5);
    endtask : t_reset
    task automatic t_rate();
        int dv [4] = '{12, 6, 4, 1};
        logic [7:0] c0;
        logic [7:0] c1;
        for (int c = 0; c < 4; c++)
        begin
            wr(PRE, 8'(c * 5));
            wr(MOD, 8'h11);
            wr(TL0, 8'h00);
            wr(TH0, 8'h00);
            wr(TL1, 8'h00);
            wr(TH1, 8'h00);
            wr(CTL, 8'h50);
            repeat (240) @(posedge clk_i);
            wr(CTL, 8'h00);
            bus(TL0, 1'b0, 8'h00, c0);
            bus(TL1, 1'b0, 8'h00, c1);
            chk_rng("rate t0", 8'(240 / dv[c] - 1), 8'(246 / dv[c] + 1), c0);
            chk_rng("rate t1", 8'(240 / dv[c] - 1), 8'(246 / dv[c] + 1), c1);
            repeat (20) @(posedge clk_i);
            rdc("halted count", TL0, c0);
        end
    endtask : t_rate
    // Overflow in one mode, then flag, mask, acknowledge and status clear
    task automatic t_ovf(input int ch, input logic [7:0] mode, input logic [7:0] lo,
                         input logic [7:0] hi, input logic [7:0] run, input int fb,
                         input logic [7:0] hmin, input logic [7:0] hmax,
                         input logic [7:0] lmin, input logic [7:0] lmax);
        logic [7:0] ilo;
        logic [7:0] ihi;
        logic [1:0] m;
        int n;
        ilo = ch ? TL1 : TL0;
        ihi = ch ? TH1 : TH0;
        m = ch ? mode[5:4] : mode[1:0];
        wr(PRE, 8'h0A);
        wr(MOD, mode);
        wr(ilo, lo);
        wr(ihi, hi);
        wr(MSK, 8'h00);
        rdc("low readback", ilo, (m == 2'b00) ? (lo & 8'h1F) : lo);
        wr(CTL, run);
        for (n = 0; n < 3000 && overflow_flag_o[fb] !== 1'b1; n++)
            @(negedge clk_i);
        chk("flag out", 8'h01, {7'h00, overflow_flag_o[fb]});
        rdc("control", CTL, run | (fb ? 8'h80 : 8'h20));
        chk("masked irq", 8'h00, {7'h00, irq_o});
        wr(MSK, 8'h03);
        repeat (2) @(negedge clk_i);
        chk("irq", 8'h01, {7'h00, irq_o});
        @(posedge clk_i);
        int_ack_i[fb] <= 1'b1;
        @(posedge clk_i);
        int_ack_i <= 2'b00;
        repeat (3) @(negedge clk_i);
        chk("acked flag", 8'h00, {7'h00, overflow_flag_o[fb]});
        wr(CTL, 8'h00);
        bus(ihi, 1'b0, 8'h00, rd);
        chk_rng("count high", hmin, hmax, rd);
        bus(ilo, 1'b0, 8'h00, rd);
        chk_rng("count low", lmin, lmax, rd);
        rdc("status", STA, 8'(1 << fb));
        wr(STA, 8'h03);
        repeat (2) @(negedge clk_i);
        chk("cleared irq", 8'h00, {7'h00, irq_o});
        wr(MSK, 8'h00);
    endtask : t_ovf
    task automatic t_cnt();
        wr(MOD, 8'h55);
        wr(TL0, 8'h00);
        wr(TL1, 8'h00);
        wr(CTL, 8'h50);
        i_dtc_pin_model.pulse(0, 5);
        i_dtc_pin_model.pulse(1, 3);
        wr(CTL, 8'h00);
        rdc("edges t0", TL0, 8'h05);
        rdc("edges t1", TL1, 8'h03);
        wr(MOD, 8'hDD);
        wr(TL0, 8'h00);
        wr(TL1, 8'h00);
        wr(CTL, 8'h50);
        i_dtc_pin_model.pulse(0, 4);
        i_dtc_pin_model.set_gate(0, 1'b1);
        i_dtc_pin_model.pulse(0, 6);
        i_dtc_pin_model.pulse(1, 2);
        wr(CTL, 8'h00);
        rdc("gated t0", TL0, 8'h06);
        rdc("gated t1", TL1, 8'h00);
    endtask : t_cnt
    task automatic t_stop1();
        wr(MOD, 8'h30);
        wr(TL1, 8'h05);
        wr(CTL, 8'h40);
        repeat (50) @(posedge clk_i);
        rdc("t1 mode 11", TL1, 8'h05);
        wr(CTL, 8'h00);
    endtask : t_stop1
    initial
    begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_rate();
        t_ovf(0, 8'h00, 8'hFE, 8'hFF, 8'h10, 0, 8'h00, 8'h00, 8'h00, 8'h1F);
        t_ovf(0, 8'h01, 8'hFE, 8'hFF, 8'h10, 0, 8'h00, 8'h00, 8'h00, 8'h1F);
        t_ovf(1, 8'h10, 8'hFE, 8'hFF, 8'h40, 1, 8'h00, 8'h00, 8'h00, 8'h1F);
        t_ovf(0, 8'h02, 8'hFE, 8'hC0, 8'h10, 0, 8'hC0, 8'hC0, 8'hC0, 8'hD0);
        t_ovf(1, 8'h20, 8'hFE, 8'hC0, 8'h40, 1, 8'hC0, 8'hC0, 8'hC0, 8'hD0);
        // Both split halves share one tick, so the low byte moves 33h to 43h in the 16 ticks the high takes to overflow
        t_ovf(0, 8'h03, 8'h33, 8'hF0, 8'h50, 1, 8'h00, 8'h0F, 8'h43, 8'h53);
        t_stop1();
        t_cnt();
        test_done();
    end
endmodule : dual_timer_event_counter_tb
`default_nettype wire
